// ---- src/qctu_timers.sv ----
// Behaviour
// R01 - four sixteen-bit counter/timers in one block
// R02 - timers 0/1: 13, 16, 8-reload; split timer0
// R03 - timers 2/3: 16-bit or dual 8-bit reload
// R04 - timers 0/1 pick among five clock sources
// R05 - timers 0/1 use prescaled or system clock
// R06 - timers 2/3: sysclk, sysclk/12, external/8
// R07 - counter mode counts falling input edges
// R08 - events up to quarter sysclk are counted
// R09 - source holds each level two clocks
// R10 - overflows raise periodic interrupt requests; split low-byte flags of timers 2/3 raise none
// R11 - prescale: /12, /4, /48, external/8
// R12 - 13-bit wrap sets flag and interrupt
// R13 - select bit picks pin edges or clock
// R14 - synchronise inputs, compare samples for edges
`timescale 1ns/1ps
module qctu_timers
	import qctu_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   ext_osc_i,
	input  wire logic [1:0]             timer_event_input_i,
	input  wire logic [1:0]             prescale_select_field_i,
	input  wire qctu_pkg::qctu_t01_cfg_t t01_cfg_i [2],
	input  wire qctu_pkg::qctu_t23_cfg_t t23_cfg_i [2],
	input  wire logic [1:0]             t01_flag_clr_i,
	input  wire logic [3:0]             t23_flag_clr_i,
	output logic      [1:0][15:0]       t01_count_o,
	output logic      [1:0][15:0]       t23_count_o,
	output logic      [1:0]             timer_overflow_flag_o,
	output logic      [3:0]             t23_flag_o,
	output logic      [3:0]             irq_o
);
	import qctu_pkg::*;

	// ----------------------------------------------------------------
	// Counting step functions
	// ----------------------------------------------------------------
	function automatic qctu_step_t step01(qctu_mode_t m, logic [15:0] c,
		logic inc);
		qctu_step_t s;
		s = '{cnt: c, ovf_lo: 1'b0, ovf_hi: 1'b0};
		if (inc)
		begin
			case (m)
				QCTU_M13:
				begin
					// Upper three low-byte bits are left untouched
					s.cnt[4:0] = c[4:0] + 5'h01;
					if (c[4:0] == QCTU_LOW5_ONES)
						s.cnt[15:8] = c[15:8] + 8'h01;
					s.ovf_lo = (c[4:0] == QCTU_LOW5_ONES)
						&& (c[15:8] == QCTU_BYTE_ONES); // see R12
				end
				QCTU_M16:
				begin
					s.cnt = c + 16'h0001;
					s.ovf_lo = (c == QCTU_WORD_ONES);
				end
				QCTU_M8AR:
				begin
					s.cnt[7:0] = (c[7:0] == QCTU_BYTE_ONES) ? c[15:8]
						: c[7:0] + 8'h01;
					s.ovf_lo = (c[7:0] == QCTU_BYTE_ONES);
				end
				default:
				begin
					s.cnt[7:0] = c[7:0] + 8'h01;
					s.ovf_lo = (c[7:0] == QCTU_BYTE_ONES);
				end
			endcase
		end
		return s;
	endfunction

	function automatic qctu_step_t step23(logic split, logic [15:0] c,
		logic [15:0] rl, logic inc_lo, logic inc_hi);
		qctu_step_t s;
		s = '{cnt: c, ovf_lo: 1'b0, ovf_hi: 1'b0};
		if (!split)
		begin
			if (inc_lo)
			begin
				s.cnt = (c == QCTU_WORD_ONES) ? rl : c + 16'h0001; // see R03
				s.ovf_hi = (c == QCTU_WORD_ONES);
			end
		end
		else
		begin
			if (inc_lo)
			begin
				s.cnt[7:0] = (c[7:0] == QCTU_BYTE_ONES) ? rl[7:0]
					: c[7:0] + 8'h01; // see R03
				s.ovf_lo = (c[7:0] == QCTU_BYTE_ONES);
			end
			if (inc_hi)
			begin
				s.cnt[15:8] = (c[15:8] == QCTU_BYTE_ONES) ? rl[15:8]
					: c[15:8] + 8'h01;
				s.ovf_hi = (c[15:8] == QCTU_BYTE_ONES);
			end
		end
		return s;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [5:0]       pre_q, pre_d;
	logic [2:0]       ext_div_q, ext_div_d;
	logic [2:0]       ext_sync_q, ext_sync_d;
	logic [1:0]       ev_s1_q, ev_s2_q, ev_s3_q;
	logic [1:0][15:0] c01_q, c01_d, c23_q, c23_d;
	logic [1:0]       f01_q, f01_d;
	logic [3:0]       f23_q, f23_d;

	logic       tick4, tick12, tick48, tick_ext8, pre_tick;
	logic [1:0] fall;
	logic [1:0] inc01;
	logic [3:0] set23;
	logic       inc_t0hi;
	qctu_step_t s01 [2];
	qctu_step_t s23 [2];

	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	// One modulo-48 counter serves /4, /12 and /48 so ticks stay aligned
	assign tick48 = (pre_q == QCTU_DIV48_LAST);
	assign tick4  = (pre_q[1:0] == QCTU_DIV4_LAST);
	assign tick12 = (pre_q == QCTU_DIV12_LAST)
		|| (pre_q == QCTU_DIV12_LAST + QCTU_DIV12_STEP)
		|| (pre_q == QCTU_DIV12_LAST + 2 * QCTU_DIV12_STEP)
		|| (pre_q == QCTU_DIV48_LAST);
	// External oscillator: sampled, rising edges counted modulo 8
	assign tick_ext8 = ext_sync_q[1] && !ext_sync_q[2]
		&& (ext_div_q == QCTU_EXT8_LAST);

	always_comb
	begin
		case (prescale_select_field_i) // see R11
			QCTU_PS_DIV12: pre_tick = tick12;
			QCTU_PS_DIV4:  pre_tick = tick4;
			QCTU_PS_DIV48: pre_tick = tick48;
			default:       pre_tick = tick_ext8;
		endcase
	end

	always_comb
	begin
		pre_d = tick48 ? 6'h00 : pre_q + 6'h01;
		ext_sync_d = {ext_sync_q[1:0], ext_osc_i};
		ext_div_d = ext_div_q;
		if (ext_sync_q[1] && !ext_sync_q[2])
			ext_div_d = ext_div_q + 3'h1;
	end

	// ----------------------------------------------------------------
	// Event input synchronisers
	// ----------------------------------------------------------------
	// Third stage only feeds the edge compare; s1 is never decoded
	assign fall = ev_s3_q & ~ev_s2_q; // see R14

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			ev_s1_q <= 2'h3;
			ev_s2_q <= 2'h3;
			ev_s3_q <= 2'h3;
		end
		else
		begin
			ev_s1_q <= timer_event_input_i; // see R08
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end

	// ----------------------------------------------------------------
	// Timers 0 and 1
	// ----------------------------------------------------------------
	// Split high byte of timer 0 runs on the timer clock, gated by
	// timer 1's run bit, and reports through timer 1's flag.
	assign inc_t0hi = t01_cfg_i[1].run
		&& (t01_cfg_i[0].sysclk_sel || pre_tick);

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_t01
			assign inc01[gi] = t01_cfg_i[gi].run
				&& (t01_cfg_i[gi].counter_mode_select ? fall[gi] // see R07
				: (t01_cfg_i[gi].sysclk_sel || pre_tick)); // see R04
			assign s01[gi] = step01(t01_cfg_i[gi].mode, c01_q[gi],
				inc01[gi] && !(gi == 1 && t01_cfg_i[1].mode == QCTU_SPLIT));
		end
		// ----------------------------------------------------------------
		// Timers 2 and 3
		// ----------------------------------------------------------------
		for (gi = 0; gi < 2; gi++)
		begin : g_t23
			logic base;
			assign base = t23_cfg_i[gi].ext_clk_sel ? tick_ext8 : tick12;
			assign s23[gi] = step23(t23_cfg_i[gi].split, c23_q[gi],
				t23_cfg_i[gi].reload,
				t23_cfg_i[gi].run && (t23_cfg_i[gi].sysclk_sel_lo || base),
				t23_cfg_i[gi].run
				&& (t23_cfg_i[gi].sysclk_sel_hi || base)); // see R06
			assign set23[2*gi]   = s23[gi].ovf_lo;
			assign set23[2*gi+1] = s23[gi].ovf_hi;
		end
	endgenerate

	always_comb
	begin
		c01_d = {s01[1].cnt, s01[0].cnt};
		c23_d = {s23[1].cnt, s23[0].cnt};
		f01_d = f01_q & ~t01_flag_clr_i;
		f23_d = (f23_q & ~t23_flag_clr_i) | set23; // see R10
		f01_d[0] = f01_d[0] | s01[0].ovf_lo; // see R12
		f01_d[1] = f01_d[1] | s01[1].ovf_lo;
		if (t01_cfg_i[0].mode == QCTU_SPLIT && inc_t0hi) // see R02
		begin
			c01_d[0][15:8] = c01_q[0][15:8] + 8'h01;
			if (c01_q[0][15:8] == QCTU_BYTE_ONES)
				f01_d[1] = 1'b1;
		end
		for (int i = 0; i < 2; i++)
		begin
			if (t01_cfg_i[i].load)
				c01_d[i] = t01_cfg_i[i].load_val;
			if (t23_cfg_i[i].load)
				c23_d[i] = t23_cfg_i[i].reload;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			pre_q      <= 6'h00;
			ext_div_q  <= 3'h0;
			ext_sync_q <= 3'h0;
			c01_q      <= {2{QCTU_CNT_RESET}};
			c23_q      <= {2{QCTU_CNT_RESET}};
			f01_q      <= 2'h0;
			f23_q      <= 4'h0;
		end
		else
		begin
			pre_q      <= pre_d;
			ext_div_q  <= ext_div_d;
			ext_sync_q <= ext_sync_d;
			c01_q      <= c01_d; // see R01
			c23_q      <= c23_d;
			f01_q      <= f01_d;
			f23_q      <= f23_d;
		end
	end

	assign t01_count_o           = c01_q;
	assign t23_count_o           = c23_q;
	assign timer_overflow_flag_o = f01_q;
	assign t23_flag_o            = f23_q;
	assign irq_o = {f23_q[3] && t23_cfg_i[1].int_en,
		f23_q[1] && t23_cfg_i[0].int_en,
		f01_q[1] && t01_cfg_i[1].int_en,
		f01_q[0] && t01_cfg_i[0].int_en}; // see R10

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_wrap13_flag: assert property ( // see R12
		t01_cfg_i[0].mode == QCTU_M13 && inc01[0] && !t01_cfg_i[0].load
		&& c01_q[0][4:0] == QCTU_LOW5_ONES && c01_q[0][15:8] == QCTU_BYTE_ONES
		|=> f01_q[0] && c01_q[0][4:0] == 5'h00 && c01_q[0][15:8] == 8'h00)
		else $error("13-bit wrap did not set flag");
	a_edge_count: assert property ( // see R07
		t01_cfg_i[0].mode == QCTU_M16 && t01_cfg_i[0].run
		&& t01_cfg_i[0].counter_mode_select && !t01_cfg_i[0].load
		&& $fell(ev_s2_q[0])
		|=> c01_q[0] == $past(c01_q[0]) + 16'h0001)
		else $error("falling edge not counted");
	a_edge_sync: assert property ( // see R14
		$fell(timer_event_input_i[0]) ##1 !timer_event_input_i[0]
		##1 !timer_event_input_i[0] |-> fall[0])
		else $error("held low input not detected after two samples");
	a_div4_tick: assert property ( // see R11
		tick4 |=> !tick4 [*3] ##1 tick4)
		else $error("divide by four period wrong");
	a_div12_gap: assert property ( // see R06
		tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
		else $error("divide by twelve period wrong");
	a_sysclk_run: assert property ( // see R05
		t01_cfg_i[1].mode == QCTU_M16 && t01_cfg_i[1].run
		&& t01_cfg_i[1].sysclk_sel && !t01_cfg_i[1].counter_mode_select
		&& !t01_cfg_i[1].load && c01_q[1] != QCTU_WORD_ONES
		|=> c01_q[1] == $past(c01_q[1]) + 16'h0001)
		else $error("system clock timer did not step");
	a_reload16: assert property ( // see R03
		!t23_cfg_i[0].split && t23_cfg_i[0].run && t23_cfg_i[0].sysclk_sel_lo
		&& !t23_cfg_i[0].load && c23_q[0] == QCTU_WORD_ONES
		|=> c23_q[0] == $past(t23_cfg_i[0].reload) && f23_q[1])
		else $error("auto-reload missing");
	a_split_hi: assert property ( // see R02
		t01_cfg_i[0].mode == QCTU_SPLIT && inc_t0hi && !t01_cfg_i[0].load
		&& c01_q[0][15:8] == QCTU_BYTE_ONES |=> f01_q[1])
		else $error("split high byte overflow lost");
	a_stopped_hold: assert property ( // see R01
		!t23_cfg_i[1].run && !t23_cfg_i[1].load |=> $stable(c23_q[1]))
		else $error("stopped timer moved");
	a_irq_flag: assert property ( // see R10
		f01_q[0] && t01_cfg_i[0].int_en |-> irq_o[0])
		else $error("interrupt request missing");

	c_wrap13: cover property (f01_q[0] && t01_cfg_i[0].mode == QCTU_M13);
	c_count: cover property (inc01[0] && t01_cfg_i[0].counter_mode_select);
	c_split23: cover property (t23_cfg_i[1].split && set23[2]);

endmodule

// ---- pkg/qctu_pkg.sv ----
package qctu_pkg;

	// Timer 0/1 operating modes, Gray coded along 13 -> 16 -> 8ar -> split
	typedef enum logic [1:0] {
		QCTU_M13   = 2'h0,
		QCTU_M16   = 2'h1,
		QCTU_M8AR  = 2'h3,
		QCTU_SPLIT = 2'h2
	} qctu_mode_t;

	// Shared prescaler field codes
	localparam logic [1:0] QCTU_PS_DIV12 = 2'h0;
	localparam logic [1:0] QCTU_PS_DIV4  = 2'h1;
	localparam logic [1:0] QCTU_PS_DIV48 = 2'h2;
	localparam logic [1:0] QCTU_PS_EXT8  = 2'h3;

	// Divider terminal counts (divisor minus one) and the /12 tick spacing
	localparam logic [5:0] QCTU_DIV48_LAST = 6'h2f;
	localparam logic [5:0] QCTU_DIV12_LAST = 6'h0b;
	localparam logic [1:0] QCTU_DIV4_LAST  = 2'h3;
	localparam logic [2:0] QCTU_EXT8_LAST  = 3'h7;
	localparam logic [5:0] QCTU_DIV12_STEP = 6'h0c;

	localparam logic [4:0]  QCTU_LOW5_ONES = 5'h1f;
	localparam logic [7:0]  QCTU_BYTE_ONES = 8'hff;
	localparam logic [15:0] QCTU_WORD_ONES = 16'hffff;
	localparam logic [15:0] QCTU_CNT_RESET = 16'h0000;

	// Configuration of one classic counter/timer
	typedef struct packed {
		logic       run;
		qctu_mode_t mode;
		logic       counter_mode_select;
		logic       sysclk_sel;
		logic       int_en;
		logic       load;
		logic [15:0] load_val;
	} qctu_t01_cfg_t;

	// Configuration of one auto-reload timer
	typedef struct packed {
		logic        run;
		logic        split;
		logic        sysclk_sel_lo;
		logic        sysclk_sel_hi;
		logic        ext_clk_sel;
		logic        int_en;
		logic        load;
		logic [15:0] reload;
	} qctu_t23_cfg_t;

	// Result of one counting step
	typedef struct packed {
		logic [15:0] cnt;
		logic        ovf_lo;
		logic        ovf_hi;
	} qctu_step_t;

endpackage

// ---- bench/qctu_ev_src.sv ----
`timescale 1ns/1ps
module qctu_ev_src (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic       start_i,
	input  wire logic [7:0] falls_i,
	input  wire logic [2:0] hold_i,
	output logic            ev_o,
	output logic            busy_o
);
	int left;
	int tick;
	// Pin idles high between bursts, so no stray fall appears
	initial ev_o = 1'b1;
	initial busy_o = 1'b0;
	always @(posedge clk_i)
	begin
		if (srst_i || start_i)
		begin
			left = srst_i ? 0 : 2 * falls_i;
			tick = 0;
			ev_o <= 1'b1;
		end
		else if (left > 0)
		begin
			tick++;
			// Never shorter than two clocks
			if (tick >= ((hold_i < 3'h2) ? 2 : hold_i))
			begin
				ev_o <= ~ev_o;
				left--;
				tick = 0;
			end
		end
		busy_o <= (left > 0);
	end
endmodule

// ---- bench/qctu_timers_tb_top.sv ----
`timescale 1ns/1ps
module qctu_timers_tb_top;
	import qctu_pkg::*;
	logic             clk_i;
	logic             srst_i;
	logic             ext_osc_i = 1'b0;
	logic [1:0]       ev;
	logic [1:0]       ps;
	qctu_t01_cfg_t    c01 [2];
	qctu_t23_cfg_t    c23 [2];
	logic [1:0]       clr01;
	logic [3:0]       clr23;
	logic [1:0][15:0] cnt01;
	logic [1:0][15:0] cnt23;
	logic [1:0][15:0] a;
	logic [1:0]       flg01;
	logic [3:0]       flg23;
	logic [3:0]       irq;
	logic [1:0]       go;
	logic [1:0]       busy;
	logic [7:0]       nf [2];
	logic [2:0]       hd [2];
	int               mismatches = 0;
	int               n_compared = 0;
	qctu_mode_t       ml [3] = '{QCTU_M13, QCTU_M16, QCTU_M8AR};
	int               pe [4] = '{8, 24, 2, 6};

	qctu_timers qctu_timers_i (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.ext_osc_i(ext_osc_i),
		.timer_event_input_i(ev),
		.prescale_select_field_i(ps),
		.t01_cfg_i(c01),
		.t23_cfg_i(c23),
		.t01_flag_clr_i(clr01),
		.t23_flag_clr_i(clr23),
		.t01_count_o(cnt01),
		.t23_count_o(cnt23),
		.timer_overflow_flag_o(flg01),
		.t23_flag_o(flg23),
		.irq_o(irq)
	);
	for (genvar g = 0; g < 2; g++)
	begin
		qctu_ev_src qctu_ev_src_i (
			.clk_i(clk_i),
			.srst_i(srst_i),
			.start_i(go[g]),
			.falls_i(nf[g]),
			.hold_i(hd[g]),
			.ev_o(ev[g]),
			.busy_o(busy[g])
		);
	end

	// ----
	// Helpers
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic drop();
		cyc(1);
		for (int i = 0; i < 2; i++)
		begin
			c01[i].load <= 1'b0;
			c23[i].load <= 1'b0;
		end
	endtask

	// Reference count after n steps; bit 16 is the overflow flag
	function automatic logic [16:0] mdl(input qctu_mode_t m,
		input logic [15:0] v, input int n);
		int         c;
		logic       f;
		logic [7:0] lo;
		f = 1'b0;
		lo = v[7:0];
		c = (m == QCTU_M13) ? {v[15:8], v[4:0]} + n : v + n;
		repeat (n)
		begin
			f = f | (lo == 8'hff);
			lo = (lo == 8'hff) ? v[15:8] : lo + 8'h01;
		end
		if (m == QCTU_M13)
			return {c > 32'h1fff, c[12:5], v[7:5], c[4:0]};
		if (m == QCTU_M16)
			return {c > 32'hffff, c[15:0]};
		return {f, v[15:8], lo};
	endfunction

	// Start values sit near the top so bursts of up to 40 falls can wrap
	task automatic ev_case(input qctu_mode_t m, input logic [2:0] h);
		logic [15:0] v [2];
		int          n [2];
		logic [16:0] e;
		logic [15:0] mk;
		mk = (m == QCTU_M13) ? 16'hff1f : 16'hffff;
		for (int i = 0; i < 2; i++)
		begin
			v[i] = 16'($urandom) | 16'hffc0;
			n[i] = 1 + $urandom % 40;
			nf[i] <= 8'(n[i]);
			hd[i] <= (i == 0) ? h : 3'(2 + $urandom % 6);
			c01[i] <= '{1'b1, m, 1'b1, 1'b0, 1'(i), 1'b1, v[i]};
		end
		go <= 2'h3;
		drop();
		go <= 2'h0;
		cyc(1);
		for (int k = 0; k < 2000 && busy != 2'h0; k++)
			cyc(1);
		cyc(8);
		for (int i = 0; i < 2; i++)
		begin
			e = mdl(m, v[i], n[i]);
			chk(cnt01[i] & mk, e[15:0] & mk);
			chk(16'(flg01[i]), 16'(e[16]));
			chk(16'(irq[i]), 16'(e[16] & i[0]));
		end
		clr01 <= 2'h3;
		cyc(1);
		clr01 <= 2'h0;
		cyc(2);
		chk(16'(flg01), 16'h0000);
	endtask

	// ----
	// Clock, oscillator, watchdog
	// ----
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
		ext_osc_i <= ~ext_osc_i;

	initial
	begin
		cyc(10000);
		mismatches++;
		close_out();
	end

	// ----
	// Tests
	// ----
	initial
	begin
		srst_i = 1'b1;
		ps = 2'h0;
		c01 = '{default: '0};
		c23 = '{default: '0};
		clr01 = 2'h0;
		clr23 = 4'h0;
		go = 2'h0;
		nf = '{default: '0};
		hd = '{default: 3'h2};
		void'($urandom(87327));
		cyc(6);
		srst_i <= 1'b0;
		cyc(2);
		chk(cnt01[0] | cnt01[1] | cnt23[0] | cnt23[1], 16'h0000);
		chk(16'({flg01, flg23, irq}), 16'h0000);
		for (int p = 0; p < 4; p++)
		begin
			ps <= 2'(p);
			c01[0] <= '{1'b1, QCTU_M16, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0100};
			c01[1] <= '{1'b1, QCTU_M16, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0100};
			drop();
			cyc(20);
			a = cnt01;
			cyc(96);
			chk(cnt01[0] - a[0], 16'(pe[p]));
			chk(cnt01[1] - a[1], 16'h0060);
		end
		c01[1] <= '{1'b1, QCTU_SPLIT, 1'b0, 1'b1, 1'b0, 1'b1, 16'h1234};
		c01[0] <= '{1'b0, QCTU_SPLIT, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0050};
		drop();
		cyc(4);
		a = cnt01;
		cyc(40);
		chk(cnt01[0], {8'(a[0][15:8] + 8'h28), 8'h50});
		chk(cnt01[1], 16'h1234);
		foreach (ml[k])
			ev_case(ml[k], 3'(2 + k));
		c23[0] <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 16'hfff0};
		c23[1] <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 16'h80fe};
		drop();
		cyc(30);
		a = cnt23;
		cyc(60);
		chk(cnt23[0], {12'hfff, 4'(a[0][3:0] + 4'hc)});
		chk(cnt23[1], {8'(a[1][15:8] + 8'h05), a[1][7:0]});
		chk(16'(flg23), 16'h0006);
		chk(16'(irq), 16'h0004);
		c23[0] <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0100};
		c23[1] <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0100};
		drop();
		clr23 <= 4'hf;
		cyc(1);
		clr23 <= 4'h0;
		cyc(20);
		a = cnt23;
		cyc(240);
		chk(cnt23[0] - a[0], 16'h000f);
		chk(cnt23[1] - a[1], 16'h0014);
		chk(16'(flg23), 16'h0000);
		close_out();
	end
endmodule
